/* core/optical_auto_calibration.sv */
// Local design decisions: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`include "optical_auto_calibration_defs.svh"

module optical_auto_calibration #(
	parameter int unsigned BLINK_CYCLES = `OAC_BLINK_CYCLES
) (
	input  wire logic                              clk,
	input  wire logic                              srst,
	input  wire logic                              cal_req_n,
	input  wire logic [`OAC_LEVEL_W-1:0]           sense_level,
	input  wire optical_auto_calibration_pkg::nv_word_t nv_restore,
	output      optical_auto_calibration_pkg::nv_word_t nv_store,
	output      logic [`OAC_DRIVE_W-1:0]           drive_code,
	output      logic                              success_indicator,
	output      logic                              failure_indicator,
	output      logic                              upper_trip_indicator,
	output      logic                              lower_trip_indicator,
	output      logic                              trip_out_upper,
	output      logic                              trip_out_lower,
	output      logic                              calibrated,
	input  wire logic [`OAC_ADDR_W-1:0]            reg_addr,
	input  wire logic [31:0]                       reg_wdata,
	input  wire logic                              reg_wr,
	input  wire logic                              reg_rd,
	output      logic [31:0]                       reg_rdata,
	output      logic                              irq
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic reg_hit(
		input logic                   strobe,
		input logic [`OAC_ADDR_W-1:0] addr,
		input logic [`OAC_ADDR_W-1:0] offset
	);
		reg_hit = strobe && (addr == offset);
	endfunction

	localparam logic [7:0] RAMP_STEP_LAST = 8'(`OAC_RAMP_STEP_CYCLES - 1);
	localparam logic [31:0] BLINK_LAST = 32'(BLINK_CYCLES - 1);
	localparam logic [2:0] BLINK_PHASES = 3'(2 * `OAC_BLINK_PULSES);

	// ----------------------------------------
	// State
	// ----------------------------------------
	optical_auto_calibration_pkg::cal_state_t state;
	optical_auto_calibration_pkg::cal_state_t next_state;

	logic                     req_n_prev;
	logic [7:0]               step_cnt;
	logic [31:0]              blink_cnt;
	logic [2:0]               blink_phase;
	logic [`OAC_EV_W-1:0]     status;
	logic [`OAC_EV_W-1:0]     mask;
	logic [`OAC_DRIVE_W-1:0]  next_drive;
	logic                     next_success;
	logic                     next_failure;

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	wire sw_start    = reg_hit(reg_wr, reg_addr, `OAC_REG_CTRL) && reg_wdata[`OAC_CTRL_START];
	wire pin_start   = req_n_prev && !cal_req_n;
	wire start       = pin_start || sw_start;
	wire step_tick   = (step_cnt == RAMP_STEP_LAST);
	wire blink_tick  = (blink_cnt == BLINK_LAST);
	wire target_hit  = (sense_level >= `OAC_CAL_TARGET);
	wire drive_top   = (drive_code == `OAC_DRIVE_MAX);
	wire is_locked   = (state == optical_auto_calibration_pkg::ST_LOCKED)
		|| (state == optical_auto_calibration_pkg::ST_BLINK);
	wire upper_now   = is_locked && (sense_level > `OAC_UPPER_TRIP);
	wire lower_now   = is_locked && (sense_level < `OAC_LOWER_TRIP);
	wire ramp_state  = (state == optical_auto_calibration_pkg::ST_RAMP);
	wire lock_now    = ramp_state && step_tick && target_hit;
	wire fail_now    = ramp_state && step_tick && !target_hit && drive_top;
	wire status_rd   = reg_hit(reg_rd, reg_addr, `OAC_REG_STATUS);

	wire [`OAC_EV_W-1:0] events;
	assign events[`OAC_EV_DONE]  = lock_now;
	assign events[`OAC_EV_FAIL]  = fail_now;
	assign events[`OAC_EV_UPPER] = upper_now != trip_out_upper;
	assign events[`OAC_EV_LOWER] = lower_now != trip_out_lower;

	wire [`OAC_EV_W-1:0] next_status;

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_comb
	begin
		next_state   = state;
		next_drive   = drive_code;
		next_success = success_indicator;
		next_failure = failure_indicator;
		if (start)
		begin
			next_state   = optical_auto_calibration_pkg::ST_RAMP;
			next_drive   = `OAC_DRIVE_ZERO;
			next_success = 1'b0;
			next_failure = 1'b0;
		end
		else
		begin
			case (state)
				optical_auto_calibration_pkg::ST_RESTORE:
				begin
					next_drive = nv_restore.valid ? nv_restore.code : `OAC_DRIVE_ZERO;
					next_state = nv_restore.valid ? optical_auto_calibration_pkg::ST_LOCKED
						: optical_auto_calibration_pkg::ST_IDLE;
				end
				optical_auto_calibration_pkg::ST_RAMP:
				begin
					if (lock_now)
					begin
						next_state   = optical_auto_calibration_pkg::ST_BLINK;
						next_success = 1'b1;
					end
					else if (fail_now)
					begin
						next_state   = optical_auto_calibration_pkg::ST_FAIL;
						next_failure = 1'b1;
					end
					else if (step_tick)
					begin
						next_drive = drive_code + 8'h01;
					end
				end
				optical_auto_calibration_pkg::ST_BLINK:
				begin
					// Lock lit the first pulse; last phase stays dark
					if (blink_tick)
					begin
						if (blink_phase == BLINK_PHASES - 3'h1)
						begin
							next_state   = optical_auto_calibration_pkg::ST_LOCKED;
							next_success = 1'b0;
						end
						else
						begin
							next_success = !success_indicator;
						end
					end
				end
				optical_auto_calibration_pkg::ST_IDLE,
				optical_auto_calibration_pkg::ST_LOCKED,
				optical_auto_calibration_pkg::ST_FAIL:
				begin
					next_state = state;
				end
				default:
				begin
					next_state = optical_auto_calibration_pkg::ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			state             <= optical_auto_calibration_pkg::ST_RESTORE;
			drive_code        <= `OAC_DRIVE_ZERO;
			success_indicator <= 1'b0;
			failure_indicator <= 1'b0;
			req_n_prev        <= 1'b1;
		end
		else
		begin
			state             <= next_state;
			drive_code        <= next_drive;
			success_indicator <= next_success;
			failure_indicator <= next_failure;
			req_n_prev        <= cal_req_n;
		end
	end

	// ----------------------------------------
	// Ramp and blink timers
	// ----------------------------------------
	always_ff @(posedge clk)
	begin
		if (srst || start || !ramp_state || step_tick)
		begin
			step_cnt <= 8'h00;
		end
		else
		begin
			step_cnt <= step_cnt + 8'h01;
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst || start || state != optical_auto_calibration_pkg::ST_BLINK)
		begin
			blink_cnt   <= 32'h0000_0000;
			blink_phase <= 3'h0;
		end
		else if (blink_tick)
		begin
			blink_cnt   <= 32'h0000_0000;
			blink_phase <= blink_phase + 3'h1;
		end
		else
		begin
			blink_cnt <= blink_cnt + 32'h0000_0001;
		end
	end

	// ----------------------------------------
	// Non-volatile store of locked drive
	// ----------------------------------------
	wire lock_store = lock_now && !start;

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			nv_store <= '0;
		end
		else
		begin
			nv_store.valid <= lock_store;
			nv_store.code  <= drive_code;
		end
	end

	// ----------------------------------------
	// Trip outputs
	// ----------------------------------------
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			trip_out_upper <= 1'b0;
			trip_out_lower <= 1'b0;
		end
		else
		begin
			trip_out_upper <= upper_now;
			trip_out_lower <= lower_now;
		end
	end

	// ----------------------------------------
	// Trip indicators
	// ----------------------------------------
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			upper_trip_indicator <= 1'b0;
			lower_trip_indicator <= 1'b0;
		end
		else
		begin
			upper_trip_indicator <= upper_now;
			lower_trip_indicator <= lower_now;
		end
	end

	// ----------------------------------------
	// Calibrated flag, follows the state
	// ----------------------------------------
	wire next_cal = (next_state == optical_auto_calibration_pkg::ST_BLINK)
		|| (next_state == optical_auto_calibration_pkg::ST_LOCKED);

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			calibrated <= 1'b0;
		end
		else
		begin
			calibrated <= next_cal;
		end
	end

	// ----------------------------------------
	// Interrupt status, set wins over read clear
	// ----------------------------------------
	genvar i;
	generate
		for (i = 0; i < `OAC_EV_W; i++)
		begin : g_status
			assign next_status[i] = events[i] || (status[i] && !status_rd);
		end
	endgenerate

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			status <= '0;
			irq    <= 1'b0;
		end
		else
		begin
			status <= next_status;
			irq    <= |(next_status & mask);
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			mask <= `OAC_MASK_RESET;
		end
		else if (reg_hit(reg_wr, reg_addr, `OAC_REG_MASK))
		begin
			mask <= reg_wdata[`OAC_EV_W-1:0];
		end
	end

	// ----------------------------------------
	// Register read
	// ----------------------------------------
	wire [31:0] drive_word = {21'h0, 3'(state), drive_code};
	wire [31:0] rd_mux =
		(reg_addr == `OAC_REG_STATUS) ? {28'h0, status} :
		(reg_addr == `OAC_REG_MASK)   ? {28'h0, mask} :
		(reg_addr == `OAC_REG_DRIVE)  ? drive_word :
		(reg_addr == `OAC_REG_LEVEL)  ? {22'h0, sense_level} :
		32'h0000_0000;

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			reg_rdata <= 32'h0000_0000;
		end
		else if (reg_rd)
		begin
			reg_rdata <= rd_mux;
		end
		else
		begin
			reg_rdata <= 32'h0000_0000;
		end
	end

endmodule

/* include/optical_auto_calibration_defs.svh */
// What this block does
// - Ramp drive from zero up to 14 mA
// - Calibration target is half the supply
// - Success indicator pulses exactly three times
// - Drive frozen until next calibration request
// - Ramp at maximum without target: failure stays on
// - Locked drive stored non-volatile, restored at power-up
// - When calibrated, upper trip output above two thirds supply
// - When calibrated, lower trip output below one third supply
// - When calibrated, upper indicator lit beyond upper trip point
// - When calibrated, lower indicator lit beyond lower trip point
`ifndef OPTICAL_AUTO_CALIBRATION_DEFS_SVH
`define OPTICAL_AUTO_CALIBRATION_DEFS_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define OAC_CLK_PERIOD_NS 5
`define OAC_RAMP_STEP_NS 1000
`define OAC_RAMP_STEP_CYCLES ((`OAC_RAMP_STEP_NS + `OAC_CLK_PERIOD_NS - 1) / `OAC_CLK_PERIOD_NS)
`define OAC_BLINK_MS 250
`define OAC_BLINK_CYCLES (`OAC_BLINK_MS * 1000000 / `OAC_CLK_PERIOD_NS)
`define OAC_BLINK_PULSES 3

// ----------------------------------------
// Levels and drive
// ----------------------------------------
`define OAC_LEVEL_W 10
`define OAC_CAL_TARGET 10'h200
`define OAC_UPPER_TRIP 10'h2AA
`define OAC_LOWER_TRIP 10'h155
`define OAC_DRIVE_W 8
`define OAC_DRIVE_MAX_UA 14000
`define OAC_DRIVE_ZERO 8'h00
`define OAC_DRIVE_MAX 8'hFF

// ----------------------------------------
// Register map
// ----------------------------------------
`define OAC_ADDR_W 5
`define OAC_REG_CTRL 5'h00
`define OAC_REG_STATUS 5'h04
`define OAC_REG_MASK 5'h08
`define OAC_REG_DRIVE 5'h0C
`define OAC_REG_LEVEL 5'h10
`define OAC_CTRL_START 0
`define OAC_EV_W 4
`define OAC_EV_DONE 0
`define OAC_EV_FAIL 1
`define OAC_EV_UPPER 2
`define OAC_EV_LOWER 3
`define OAC_MASK_RESET 4'h0
`define OAC_DRIVE_STATE_LSB 8

`endif

/* include/optical_auto_calibration_pkg.sv */
`include "optical_auto_calibration_defs.svh"

package optical_auto_calibration_pkg;

	typedef enum logic [2:0]
	{
		ST_RESTORE,
		ST_IDLE,
		ST_RAMP,
		ST_BLINK,
		ST_LOCKED,
		ST_FAIL
	} cal_state_t;

	// Word exchanged with the non-volatile store
	typedef struct packed
	{
		logic                     valid;
		logic [`OAC_DRIVE_W-1:0]  code;
	} nv_word_t;

endpackage

/* tb/optical_auto_calibration_bench.sv */
`timescale 1ns/1ps
`include "optical_auto_calibration_defs.svh"

module optical_auto_calibration_bench;
	logic        clk = 1'b0, srst = 1'b1, cal_req_n = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [4:0]  reg_addr = 5'h00;
	logic [31:0] reg_wdata = 32'h0, reg_rdata;
	logic [3:0]  gain = 4'h0;
	logic [9:0]  sense_level;
	logic [7:0]  drive_code, nv_seen;
	logic        success_indicator, failure_indicator, upper_trip_indicator;
	logic        lower_trip_indicator, trip_out_upper, trip_out_lower, calibrated, irq;
	logic        last_success = 1'b0;
	int          fail_count = 0, total_checks = 0, cycles = 0, pulses = 0;
	optical_auto_calibration_pkg::nv_word_t nv_restore = '0, nv_store;

	optical_auto_calibration #(.BLINK_CYCLES(4)) i_optical_auto_calibration (.clk, .srst,
		.cal_req_n, .sense_level, .nv_restore, .nv_store, .drive_code, .success_indicator,
		.failure_indicator, .upper_trip_indicator, .lower_trip_indicator, .trip_out_upper,
		.trip_out_lower, .calibrated, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq);
	optical_sensor_pair i_optical_sensor_pair (.drive_code, .gain, .sense_level);

	always #2.5 clk = ~clk;

	// Pulse counting, store capture, hang limit
	always @(posedge clk)
	begin
		cycles++;
		last_success <= success_indicator;
		if (success_indicator === 1'b1 && last_success === 1'b0)
			pulses++;
		if (nv_store.valid === 1'b1)
			nv_seen <= nv_store.code;
		if (cycles == 95000)
		begin
			fail_count++;
			report_and_stop();
		end
	end

	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e)
		begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask

	task report_and_stop();
		if (fail_count == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task rd(input logic [4:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask

	task req();
		@(posedge clk);
		cal_req_n <= 1'b0;
		@(posedge clk);
		cal_req_n <= 1'b1;
	endtask

	task t_cal();
		logic [31:0] d;
		gain <= 4'h8;
		pulses = 0;
		req();
		repeat (2) @(posedge clk);
		#1 chk("drive_start", drive_code, 8'h00);
		for (int i = 0; i < 20000 && calibrated !== 1'b1; i++) @(posedge clk);
		#1 chk("drive_lock", drive_code, 8'h40);
		repeat (40) @(posedge clk);
		chk("pulses", pulses, 3);
		chk("success_off", success_indicator, 1'b0);
		chk("nv_code", nv_seen, 8'h40);
		chk("irq_masked", irq, 1'b0);
		wr(`OAC_REG_MASK, 32'hF);
		repeat (2) @(posedge clk);
		#1 chk("irq_set", irq, 1'b1);
		rd(`OAC_REG_STATUS, d);
		chk("status_done", d[0], 1'b1);
		repeat (2) @(posedge clk);
		#1 chk("irq_clear", irq, 1'b0);
		@(posedge clk) gain <= 4'hC;
		repeat (3) @(posedge clk);
		#1 chk("upper", {trip_out_upper, upper_trip_indicator, trip_out_lower}, 3'b110);
		@(posedge clk) gain <= 4'h4;
		repeat (3) @(posedge clk);
		#1 chk("lower", {trip_out_upper, trip_out_lower, lower_trip_indicator}, 3'b011);
		chk("drive_held", drive_code, 8'h40);
		rd(`OAC_REG_DRIVE, d);
		chk("drive_reg", d, 32'h0000_0440);
		rd(`OAC_REG_LEVEL, d);
		chk("level_reg", d, 32'h0000_0100);
	endtask

	task t_fail();
		logic [31:0] d;
		@(posedge clk) gain <= 4'h0;
		wr(`OAC_REG_CTRL, 32'h1);
		for (int i = 0; i < 60000 && failure_indicator !== 1'b1; i++) @(posedge clk);
		#1 chk("fail", {failure_indicator, calibrated, drive_code}, {2'b10, 8'hFF});
		repeat (50) @(posedge clk);
		#1 chk("fail_held", failure_indicator, 1'b1);
		rd(`OAC_REG_STATUS, d);
		chk("status_fail", d[3:0], 4'hE);
		rd(5'h1C, d);
		chk("unmapped", d, 32'h0);
		rd(`OAC_REG_MASK, d);
		chk("mask", d[3:0], 4'hF);
		req();
		@(posedge clk);
		#1 chk("fail_clear", {failure_indicator, drive_code}, 9'h000);
	endtask

	task t_restore();
		@(posedge clk);
		nv_restore <= {1'b1, 8'h33};
		srst <= 1'b1;
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		repeat (3) @(posedge clk);
		#1 chk("restore", {calibrated, drive_code}, {1'b1, 8'h33});
	endtask

	initial
	begin
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		repeat (2) @(posedge clk);
		#1 chk("reset", {calibrated, failure_indicator, drive_code}, 10'h000);
		t_cal();
		t_fail();
		t_restore();
		report_and_stop();
	end
endmodule

bind optical_auto_calibration optical_auto_calibration_sva i_optical_auto_calibration_sva (
	.clk, .srst, .cal_req_n, .sense_level, .nv_store, .drive_code, .success_indicator,
	.failure_indicator, .upper_trip_indicator, .lower_trip_indicator, .trip_out_upper,
	.trip_out_lower, .calibrated, .reg_addr, .reg_wdata, .reg_wr);

/* tb/optical_auto_calibration_sva.sv */
`timescale 1ns/1ps
`include "optical_auto_calibration_defs.svh"

module optical_auto_calibration_sva (
	input wire logic                                   clk,
	input wire logic                                   srst,
	input wire logic                                   cal_req_n,
	input wire logic [9:0]                             sense_level,
	input wire optical_auto_calibration_pkg::nv_word_t nv_store,
	input wire logic [7:0]                             drive_code,
	input wire logic                                   success_indicator,
	input wire logic                                   failure_indicator,
	input wire logic                                   upper_trip_indicator,
	input wire logic                                   lower_trip_indicator,
	input wire logic                                   trip_out_upper,
	input wire logic                                   trip_out_lower,
	input wire logic                                   calibrated,
	input wire logic [4:0]                             reg_addr,
	input wire logic [31:0]                            reg_wdata,
	input wire logic                                   reg_wr
);
	logic [7:0]  last_drive;
	logic [15:0] held;
	wire         ctrl_start = reg_wr && reg_addr == `OAC_REG_CTRL && reg_wdata[0];

	// Cycles the current drive value has stood
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			last_drive <= 8'h00;
			held <= 16'h0000;
		end
		else
		begin
			last_drive <= drive_code;
			held <= (drive_code != last_drive) ? 16'h0001 : held + 16'h0001;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (srst);

	AST_START_CLEARS:
		assert property ($fell(cal_req_n) || ctrl_start |=> drive_code == 8'h00
			&& !failure_indicator && !success_indicator) else $error("start not cleared");
	AST_STEP_SPACING:
		assert property (drive_code != last_drive && drive_code == last_drive + 8'h01
			&& last_drive != 8'h00 && last_drive != 8'hFF && !calibrated |-> held == 16'd200)
			else $error("step gap");
	AST_LOCK_TARGET:
		assert property ($rose(calibrated) && !$past(srst) && !$past(srst, 2)
			|-> $past(sense_level) >= `OAC_CAL_TARGET) else $error("lock below target");
	AST_SUCCESS_CAL:
		assert property (success_indicator |-> calibrated) else $error("success uncalibrated");
	AST_DRIVE_FROZEN:
		assert property (calibrated && !$fell(cal_req_n) && !ctrl_start |=> $stable(drive_code))
			else $error("drive moved when locked");
	AST_FAIL_AT_MAX:
		assert property (failure_indicator |-> drive_code == 8'hFF && !calibrated)
			else $error("fail below max");
	AST_FAIL_HOLD:
		assert property (failure_indicator && !$fell(cal_req_n) && !ctrl_start |=> failure_indicator)
			else $error("fail dropped");
	AST_NV_STORE:
		assert property (nv_store.valid |-> nv_store.code == drive_code && calibrated)
			else $error("bad store word");
	AST_UPPER_TRIP:
		assert property (calibrated && $past(calibrated) |-> upper_trip_indicator == trip_out_upper
			&& trip_out_upper == ($past(sense_level) > `OAC_UPPER_TRIP)) else $error("upper trip");
	AST_LOWER_TRIP:
		assert property (calibrated && $past(calibrated) |-> lower_trip_indicator == trip_out_lower
			&& trip_out_lower == ($past(sense_level) < `OAC_LOWER_TRIP)) else $error("lower trip");
endmodule

/* tb/optical_sensor_pair.sv */
`timescale 1ns/1ps

module optical_sensor_pair (
	input  wire logic [7:0] drive_code,
	input  wire logic [3:0] gain,
	output      logic [9:0] sense_level
);
	logic [11:0] photo;

	// Light seen grows with drive, clipped at supply
	assign photo = drive_code * gain;
	assign sense_level = (photo > 12'h3FF) ? 10'h3FF : photo[9:0];
endmodule
